// ---- arc_pkg.sv ----
// package with register map, field layout and state types for the converter
// Overview of operation
// R01: writing control register 1 aborts and restarts, unless channel is all ones
// R02: done flag sets at conversion end, or only on compare hit when enabled
// R03: done flag clears on control register 1 write or low result read
// R04: interrupt asserts while done flag set and interrupt enable high
// R05: continuous bit off gives one conversion per trigger, on repeats
// R06: channel field 4:0 selects inputs 0..27, high and low references
// R07: channel all ones turns converter off; no extra conversion follows
// R08: single mode returns core to low power after each conversion
// R09: active bit sets at conversion start, clears on completion or abort
// R10: trigger select picks register write or hardware trigger input
// R11: software writes zeros to control register 2 bits 1 and 0
// R12: compare enable bit turns automatic compare on or off
// R13: compare direction: 0 less than, 1 greater or equal
// R14: results update each conversion unless compare enabled and missed
// R15: high result holds bits 9:8 in 10-bit mode, zero in 8-bit mode
// R16: 10-bit high byte read locks result transfers until low byte read
// R17: mode field change invalidates both result registers
// R18: compare high bits 9:8 used only in 10-bit mode, low always
// R19: configuration bit 7 selects low power converter configuration
// R20: divider field 6:5 divides input clock by 1, 2, 4 or 8
// R21: configuration bit 4 selects long sample period
// R22: mode field 3:2 selects resolution, 00 is 8-bit
// R23: mode 10 is 10-bit; 01 and 11 are reserved
// R24: clock select 1:0: bus, bus halved, alternate, asynchronous
// R25: hardware trigger is not connected; software trigger path suffices
// R26: reset clears fields, channel all ones, results cleared
package arc_pkg;
  localparam logic [2:0] ARC_OFS_SC1 = 3'h0;
  localparam logic [2:0] ARC_OFS_SC2 = 3'h1;
  localparam logic [2:0] ARC_OFS_RH = 3'h2;
  localparam logic [2:0] ARC_OFS_RL = 3'h3;
  localparam logic [2:0] ARC_OFS_CVH = 3'h4;
  localparam logic [2:0] ARC_OFS_CVL = 3'h5;
  localparam logic [2:0] ARC_OFS_CFG = 3'h6;
  localparam int ARC_DONE_BIT = 7;
  localparam int ARC_DONE_INTERRUPT_ENABLE_BIT = 6;
  localparam int ARC_CONT_BIT = 5;
  localparam int ARC_ACT_BIT = 7;
  localparam int ARC_TRG_BIT = 6;
  localparam int ARC_CFE_BIT = 5;
  localparam int ARC_CGE_BIT = 4;
  localparam logic [4:0] ARC_CH_OFF = 5'h1f;
  localparam logic [4:0] ARC_CH_HIGH_REFERENCE = 5'h1d;
  localparam logic [4:0] ARC_CH_LOW_REFERENCE = 5'h1e;
  localparam logic [4:0] ARC_CH_RSVD = 5'h1c;
  localparam logic [1:0] ARC_MODE_8 = 2'h0;
  localparam logic [1:0] ARC_MODE_10 = 2'h2;
  localparam logic [7:0] ARC_CFG_RST = 8'h00;
  localparam logic [9:0] ARC_RES_RST = 10'h000;
  // divider counter reset value
  localparam logic [2:0] ARC_DIV_RST = 3'h0;

  typedef struct packed {
    logic done_interrupt_enable;
    logic cont;
    logic [4:0] chan;
  } arc_sc1_t;

  typedef struct packed {
    logic trg;
    logic cfe;
    logic cge;
  } arc_sc2_t;

  typedef enum logic [1:0] {ARC_IDLE, ARC_BUSY} arc_state_t;

  // request to / answer from the approximation core
  typedef struct packed {
    logic start;
    logic abort;
    logic [4:0] chan;
    logic ten_bit;
    logic long_smp;
    logic low_power;
    logic powered;
  } arc_core_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] value;
  } arc_core_ans_t;
endpackage : arc_pkg

// ---- arc_clkdiv.sv ----
// conversion clock divider: source select and divide by 1, 2, 4 or 8
`timescale 1ns/10ps
module arc_clkdiv
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [1:0] div_sel_i,
  input wire logic alt_tick_i,
  input wire logic async_tick_i,
  output logic tick_o
);
  typedef struct packed {
    logic half;
    logic [2:0] cnt;
    logic tick;
  } arc_div_st_t;

  arc_div_st_t st_r;
  arc_div_st_t st_nxt;
  logic src_tick;
  logic [2:0] lim;

  // pick the input clock source
  always_comb begin
    st_nxt = st_r;
    unique case (src_sel_i) // R24
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = st_r.half;
      2'h2: src_tick = alt_tick_i;
      2'h3: src_tick = async_tick_i;
    endcase
    lim = 3'((4'h1 << div_sel_i) - 4'h1); // R20
    st_nxt.half = ~st_r.half;
    st_nxt.tick = 1'b0;
    if (src_tick) begin
      if (st_r.cnt >= lim) begin
        st_nxt.cnt = ARC_DIV_RST;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;
endmodule : arc_clkdiv

// ---- arc_compare.sv ----
// automatic compare of a result against the compare value
`timescale 1ns/10ps
module arc_compare
  import arc_pkg::*;
(
  input wire logic [9:0] result_i,
  input wire logic [9:0] level_i,
  input wire logic ten_bit_i,
  input wire logic enable_i,
  input wire logic ge_i,
  output logic accept_o
);
  logic [9:0] a;
  logic [9:0] b;
  logic hit;

  // high compare bits only count in 10-bit mode
  always_comb begin
    a = ten_bit_i ? result_i : {2'h0, result_i[7:0]}; // R18
    b = ten_bit_i ? level_i : {2'h0, level_i[7:0]}; // R18
    hit = ge_i ? (a >= b) : (a < b); // R13
    accept_o = !enable_i || hit; // R12
  end
endmodule : arc_compare

// ---- arc_adc_ctrl.sv ----
// register control for the successive approximation converter
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module arc_adc_ctrl
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic hardware_trigger_in_i,
  input wire logic alternate_clock_i,
  input wire logic async_conversion_clock_i,
  input wire logic core_done_i,
  input wire logic [9:0] core_value_i,
  output logic core_start_o,
  output logic core_abort_o,
  output logic [4:0] core_chan_o,
  output logic core_ten_bit_o,
  output logic core_long_smp_o,
  output logic core_low_power_o,
  output logic core_powered_o,
  output logic conversion_clock_o,
  output logic irq_o
);
  typedef struct packed {
    arc_sc1_t sc1;
    arc_sc2_t sc2;
    logic [7:0] cfg;
    logic [1:0] cvh;
    logic [7:0] cvl;
    logic [9:0] res;
    logic done;
    logic locked;
    arc_state_t state;
    logic powered;
    logic trg_d;
    logic [7:0] rdata;
    arc_core_req_t req;
    logic irq;
    logic cclk;
  } arc_st_t;

  arc_st_t st_r;
  arc_st_t st_nxt;
  logic tick;
  logic accept;
  logic [1:0] mode;
  logic ten_bit;
  logic wr_sc1;
  logic wr_cfg;
  logic rd_rl;
  logic rd_rh;
  logic trig_edge;
  logic start;
  logic [9:0] shaped;
  arc_core_ans_t ans;

  assign ans.done = core_done_i;
  assign ans.value = core_value_i;
  assign mode = st_r.cfg[3:2];
  assign ten_bit = (mode == ARC_MODE_10); // R23

  // conversion clock derivation
  arc_clkdiv u_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .src_sel_i(st_r.cfg[1:0]),
    .div_sel_i(st_r.cfg[6:5]),
    .alt_tick_i(alternate_clock_i),
    .async_tick_i(async_conversion_clock_i),
    .tick_o(tick)
  );

  // 8-bit results drop the top bits
  assign shaped = ten_bit ? ans.value : {2'h0, ans.value[7:0]}; // R15

  arc_compare u_cmp (
    .result_i(shaped),
    .level_i({st_r.cvh, st_r.cvl}),
    .ten_bit_i(ten_bit),
    .enable_i(st_r.sc2.cfe),
    .ge_i(st_r.sc2.cge),
    .accept_o(accept)
  );

  // bus decode
  always_comb begin
    wr_sc1 = wr_i && (addr_i == ARC_OFS_SC1);
    wr_cfg = wr_i && (addr_i == ARC_OFS_CFG);
    rd_rl = rd_i && (addr_i == ARC_OFS_RL);
    rd_rh = rd_i && (addr_i == ARC_OFS_RH);
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.req.start = 1'b0;
    st_nxt.req.abort = 1'b0;
    st_nxt.trg_d = hardware_trigger_in_i;
    trig_edge = hardware_trigger_in_i && !st_r.trg_d;
    start = 1'b0;
    // register writes
    if (wr_i) begin
      unique case (addr_i)
        ARC_OFS_SC1: begin
          st_nxt.sc1.done_interrupt_enable = wdata_i[ARC_DONE_INTERRUPT_ENABLE_BIT];
          st_nxt.sc1.cont = wdata_i[ARC_CONT_BIT];
          st_nxt.sc1.chan = wdata_i[4:0]; // R06
        end
        ARC_OFS_SC2: begin
          // bits 1:0 written as zero by software, ignored here
          st_nxt.sc2.trg = wdata_i[ARC_TRG_BIT]; // R10 R11
          st_nxt.sc2.cfe = wdata_i[ARC_CFE_BIT]; // R12
          st_nxt.sc2.cge = wdata_i[ARC_CGE_BIT]; // R13
        end
        ARC_OFS_CVH: st_nxt.cvh = wdata_i[1:0];
        ARC_OFS_CVL: st_nxt.cvl = wdata_i;
        ARC_OFS_CFG: st_nxt.cfg = wdata_i; // R19 R20 R21 R22
        default: ;
      endcase
    end
    // mode change invalidates the results
    if (wr_cfg && (wdata_i[3:2] != mode)) begin
      st_nxt.res = ARC_RES_RST; // R17
      st_nxt.locked = 1'b0;
    end
    // high byte read locks transfer in 10-bit mode
    if (rd_rh && ten_bit) begin
      st_nxt.locked = 1'b1; // R16
    end
    if (rd_rl) begin
      st_nxt.locked = 1'b0; // R16
    end
    // conversion end
    if (st_r.state == ARC_BUSY && ans.done) begin
      st_nxt.state = ARC_IDLE; // R09
      if (accept) begin
        st_nxt.done = 1'b1; // R02
        if (!st_r.locked || !ten_bit) begin
          st_nxt.res = shaped; // R14 R15
        end
      end
      if (st_r.sc1.cont && st_r.sc1.chan != ARC_CH_OFF) begin
        start = 1'b1; // R05
      end else if (!st_r.sc1.cont) begin
        st_nxt.powered = 1'b0; // R08
      end
    end
    // done flag clears; a same-cycle set wins only while the flag is clear
    if ((wr_sc1 || rd_rl) && !(st_nxt.done && !st_r.done)) begin
      st_nxt.done = 1'b0; // R03
    end
    if (wr_sc1 && st_r.state == ARC_BUSY) begin
      // a new write ends any conversion in progress
      st_nxt.req.abort = 1'b1; // R01
      st_nxt.state = ARC_IDLE; // R09
      start = 1'b0;
    end
    if (wr_sc1 && wdata_i[4:0] != ARC_CH_OFF && !st_r.sc2.trg) begin
      start = 1'b1; // R01 R10
    end
    // hardware trigger path; unconnected on this part
    if (st_r.sc2.trg && trig_edge && st_r.sc1.chan != ARC_CH_OFF
        && st_r.state == ARC_IDLE && !wr_sc1) begin
      start = 1'b1; // R10 R25
    end
    if (st_nxt.sc1.chan == ARC_CH_OFF) begin
      // disabled: no further conversion, core off
      start = 1'b0; // R07
      st_nxt.powered = 1'b0; // R07
      if (st_r.state == ARC_BUSY && !wr_sc1) begin
        st_nxt.req.abort = 1'b1; // R07
      end
      st_nxt.state = ARC_IDLE;
    end
    if (start) begin
      st_nxt.state = ARC_BUSY; // R09
      st_nxt.powered = 1'b1;
      st_nxt.req.start = 1'b1;
    end
    st_nxt.irq = st_nxt.done && st_nxt.sc1.done_interrupt_enable; // R04
    st_nxt.cclk = tick && st_nxt.powered;
    st_nxt.req.chan = st_nxt.sc1.chan; // R06
    st_nxt.req.ten_bit = (st_nxt.cfg[3:2] == ARC_MODE_10);
    st_nxt.req.long_smp = st_nxt.cfg[4]; // R21
    st_nxt.req.low_power = st_nxt.cfg[7]; // R19
    st_nxt.req.powered = st_nxt.powered;
    // read data, one cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        ARC_OFS_SC1:
          st_nxt.rdata = {st_r.done, st_r.sc1.done_interrupt_enable, st_r.sc1.cont,
                          st_r.sc1.chan};
        ARC_OFS_SC2:
          st_nxt.rdata = {st_r.state == ARC_BUSY, st_r.sc2.trg,
                          st_r.sc2.cfe, st_r.sc2.cge, 4'h0};
        ARC_OFS_RH: st_nxt.rdata = {6'h00, st_r.res[9:8]};
        ARC_OFS_RL: st_nxt.rdata = st_r.res[7:0];
        ARC_OFS_CVH: st_nxt.rdata = {6'h00, st_r.cvh};
        ARC_OFS_CVL: st_nxt.rdata = st_r.cvl;
        ARC_OFS_CFG: st_nxt.rdata = st_r.cfg;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register, R26 reset values
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.sc1.chan <= ARC_CH_OFF; // R26
      st_r.cfg <= ARC_CFG_RST; // R26
      st_r.res <= ARC_RES_RST; // R26
      st_r.req.chan <= ARC_CH_OFF;
      st_r.state <= ARC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign irq_o = st_r.irq;
  assign conversion_clock_o = st_r.cclk;
  assign core_start_o = st_r.req.start;
  assign core_abort_o = st_r.req.abort;
  assign core_chan_o = st_r.req.chan;
  assign core_ten_bit_o = st_r.req.ten_bit;
  assign core_long_smp_o = st_r.req.long_smp;
  assign core_low_power_o = st_r.req.low_power;
  assign core_powered_o = st_r.req.powered;
endmodule : arc_adc_ctrl

// ---- arc_adc_checker.sv ----
// checker for the converter register control ports
`timescale 1ns/10ps
module arc_adc_checker
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic core_done_i,
  input wire logic core_start_o,
  input wire logic core_abort_o,
  input wire logic [4:0] core_chan_o,
  input wire logic core_powered_o,
  input wire logic irq_o
);
  logic cont_r;
  logic trg_r;
  logic busy_r;
  logic busy;
  // busy from the start pulse on, as the control state sees it
  assign busy = core_start_o | busy_r;
  // shadows of continuous and trigger bits, core busy
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cont_r <= 1'b0;
      trg_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == ARC_OFS_SC1)
        cont_r <= wdata_i[ARC_CONT_BIT];
      if (wr_i && addr_i == ARC_OFS_SC2)
        trg_r <= wdata_i[ARC_TRG_BIT];
      busy_r <= busy & ~core_done_i & ~(wr_i && addr_i == ARC_OFS_SC1);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wr1;
    wr_i && addr_i == ARC_OFS_SC1;
  endsequence
  sequence s_rdlo;
    rd_i && addr_i == ARC_OFS_RL && !core_done_i;
  endsequence
  chk_write_start: assert property (s_wr1 ##0
    (wdata_i[4:0] != ARC_CH_OFF && !trg_r) |=> core_start_o)
    else $error("no start after control write");
  chk_off_idle: assert property (s_wr1 ##0
    wdata_i[4:0] == ARC_CH_OFF ##1 !wr_i
    |-> (!core_start_o && !core_powered_o)[*2])
    else $error("converter not off");
  chk_chan_follow: assert property (s_wr1
    |=> core_chan_o == $past(wdata_i[4:0]))
    else $error("channel not passed on");
  chk_abort_busy: assert property (s_wr1 ##0
    (busy && !core_done_i) |=> core_abort_o)
    else $error("no abort on rewrite");
  chk_done_irq: assert property ($rose(irq_o) |-> $past(core_done_i))
    else $error("interrupt without completion");
  chk_clear_wr: assert property (s_wr1 ##0 !core_done_i |=> !irq_o)
    else $error("flag kept after write");
  chk_clear_rd: assert property (s_rdlo |=> !irq_o)
    else $error("flag kept after low read");
  chk_single_idle: assert property (core_done_i && !cont_r && !wr_i
    |=> ##[0:1] !core_powered_o)
    else $error("no low power after single");
  chk_cont_again: assert property (core_done_i && cont_r && !wr_i
    |=> ##[0:1] core_start_o)
    else $error("continuous did not restart");
endmodule : arc_adc_checker

bind arc_adc_ctrl arc_adc_checker u_chk (.clk_i, .reset_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .core_done_i, .core_start_o, .core_abort_o,
  .core_chan_o, .core_powered_o, .irq_o);

// ---- arc_core_model.sv ----
// behavioural approximation core answering after a set latency
`timescale 1ns/10ps
module arc_core_model
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] lat_i,
  input wire logic [9:0] sample_i,
  output logic done_o,
  output logic [9:0] value_o
);
  logic [7:0] cnt_r;
  logic [9:0] hold_r;
  // value shows its inverse outside the done pulse
  assign value_o = done_o ? hold_r : ~hold_r;
  // count a conversion down; abort cancels it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 8'h00;
      hold_r <= 10'h000;
      done_o <= 1'b0;
    end else begin
      done_o <= cnt_r == 8'h01 && !start_i && !abort_i;
      if (start_i) begin
        cnt_r <= lat_i;
        hold_r <= sample_i;
      end else if (abort_i || cnt_r == 8'h01)
        cnt_r <= 8'h00;
      else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : arc_core_model

// ---- tb_arc_adc_ctrl.sv ----
// self-checking bench for the converter register control
`timescale 1ns/10ps
module tb_arc_adc_ctrl;
  import arc_pkg::*;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic [2:0] addr_i = 0;
  logic [7:0] wdata_i = 0;
  logic wr_i = 0, rd_i = 0, alt_i = 0, asy_i = 0, rd_d = 0;
  logic cdone, cstart, cabort, irq;
  logic [7:0] rdata, lat = 8'h10, cfg;
  logic [9:0] smp = 10'h000, cval;
  logic [7:0] exp_q[$];
  int fail_count = 0, checked = 0;

  always #4 clk_i = ~clk_i;
  // random ticks for the alternate and asynchronous sources
  always @(posedge clk_i) {alt_i, asy_i} <= 2'($urandom);

  arc_adc_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .hardware_trigger_in_i(1'b0),
    .alternate_clock_i(alt_i), .async_conversion_clock_i(asy_i),
    .core_done_i(cdone), .core_value_i(cval), .core_start_o(cstart),
    .core_abort_o(cabort), .core_chan_o(), .core_ten_bit_o(),
    .core_long_smp_o(), .core_low_power_o(), .core_powered_o(),
    .conversion_clock_o(), .irq_o(irq));
  arc_core_model core (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .start_i(cstart), .abort_i(cabort), .lat_i(lat), .sample_i(smp),
    .done_o(cdone), .value_o(cval));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  task automatic ck(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t interrupt level wrong", $time);
    end
  endtask : ck

  // wait for the core to finish, then let the flags land
  task automatic conv();
    int n;
    n = 0;
    while (cdone !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 500)
      @(posedge clk_i);
    else begin
      fail_count++;
      $display("ERROR %0t conversion never ended", $time);
      wrap_up();
    end
  endtask : conv

  // read data compared with the oldest note
  always @(posedge clk_i) begin
    if (rd_d) begin
      checked++;
      if (rdata !== exp_q[0]) begin
        fail_count++;
        $display("ERROR %0t read %h not %h", $time, rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    rd_d <= rd_i;
  end

  initial begin
    #400000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    void'($urandom(32'ha332));
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(ARC_OFS_SC1, 8'h1f);
    rd(ARC_OFS_CFG, 8'h00);
    rd(ARC_OFS_RL, 8'h00);
    rd(3'h7, 8'h00);
    // single 8-bit conversions with interrupt on every channel code except all ones
    for (int c = 0; c < 31; c++) begin
      smp = 10'($urandom);
      lat = 8'($urandom_range(40, 2));
      wr(ARC_OFS_SC1, 8'h40 | 8'(c));
      conv();
      ck(irq);
      rd(ARC_OFS_SC1, 8'hc0 | 8'(c));
      rd(ARC_OFS_RH, 8'h00);
      rd(ARC_OFS_RL, smp[7:0]);
      rd(ARC_OFS_SC1, 8'h40 | 8'(c));
    end
    // continuous run, rewrite mid-conversion, then switch off
    lat = 8'h1e;
    wr(ARC_OFS_SC1, 8'h25);
    wr(ARC_OFS_SC1, 8'h25);
    rd(ARC_OFS_SC2, 8'h80);
    conv();
    conv();
    wr(ARC_OFS_SC1, 8'h1f);
    rd(ARC_OFS_SC2, 8'h00);
    // 10-bit mode: a high byte read locks the result pair
    cfg = 8'($urandom);
    cfg[3:2] = ARC_MODE_10;
    wr(ARC_OFS_CFG, cfg);
    rd(ARC_OFS_CFG, cfg);
    for (int i = 0; i < 3; i++) begin
      smp = i == 1 ? 10'h155 : 10'h3c7 - 10'(i);
      wr(ARC_OFS_SC1, 8'h03);
      conv();
      // the second result is lost while the pair is locked
      rd(ARC_OFS_RH, 8'h03);
      if (i != 0)
        rd(ARC_OFS_RL, i == 1 ? 8'hc7 : 8'hc5);
    end
    wr(ARC_OFS_CFG, 8'h00);
    rd(ARC_OFS_RL, 8'h00);
    rd(ARC_OFS_RH, 8'h00);
    // compare less-than misses, greater-equal hits, high value ignored
    wr(ARC_OFS_CVH, 8'h02);
    wr(ARC_OFS_CVL, 8'h40);
    rd(ARC_OFS_CVL, 8'h40);
    rd(ARC_OFS_CVH, 8'h02);
    for (int i = 0; i < 2; i++) begin
      smp = 10'h050;
      wr(ARC_OFS_SC2, i == 1 ? 8'h30 : 8'h20);
      wr(ARC_OFS_SC1, 8'h42);
      conv();
      ck(irq === (i == 1));
      rd(ARC_OFS_SC1, i == 1 ? 8'hc2 : 8'h42);
      rd(ARC_OFS_RL, i == 1 ? 8'h50 : 8'h00);
    end
    rd(ARC_OFS_SC2, 8'h30);
    // hardware trigger selected: a control write starts nothing
    wr(ARC_OFS_SC2, 8'h40);
    wr(ARC_OFS_SC1, 8'h45);
    rd(ARC_OFS_SC2, 8'h40);
    rd(ARC_OFS_SC1, 8'h45);
    repeat (2) @(posedge clk_i);
    wrap_up();
  end
endmodule : tb_arc_adc_ctrl
